// ---- src/lch_pkg.sv ----
package lch_pkg;

   // ==========================================================
   // sizes
   localparam int LCH_LINES = 4;
   localparam int LCH_LINE_W = 2;
   localparam int LCH_ADDR_W = 8;
   localparam int LCH_TMR_W = 32;
   localparam int LCH_CFG_W = 7;

   // ==========================================================
   // timing
   localparam longint unsigned LCH_CLK_PERIOD_NS = 4;
   localparam longint unsigned LCH_CHAR_TIME_NS = 100000000;   // one character time
   localparam int unsigned LCH_CHAR_CYC = int'(LCH_CHAR_TIME_NS / LCH_CLK_PERIOD_NS);

   // ==========================================================
   // register byte addresses
   localparam logic [7:0] LCH_A_CMD = 8'h00;
   localparam logic [7:0] LCH_A_HALT = 8'h04;
   localparam logic [7:0] LCH_A_STATUS = 8'h08;
   localparam logic [7:0] LCH_A_SDATA = 8'h0C;
   localparam logic [7:0] LCH_A_CFG0 = 8'h10;
   localparam logic [7:0] LCH_A_LSTATE = 8'h20;

   // register field positions
   localparam int LCH_CMD_LINE_LSB = 8;
   localparam int LCH_ST_LINE_LSB = 8;
   localparam int LCH_ST_VALID_BIT = 16;
   localparam int LCH_SD_VALID_BIT = 8;
   localparam int LCH_LS_BUSY_LSB = 4;
   localparam int LCH_LS_PEND_LSB = 8;

   // per-line configuration fields
   localparam int LCH_CFG_TYPE_LSB = 0;
   localparam int LCH_CFG_ACALL = 3;
   localparam int LCH_CFG_STASEL = 4;
   localparam int LCH_CFG_TWAIT = 5;
   localparam int LCH_CFG_INTR = 6;

   // ==========================================================
   // line types
   localparam logic [2:0] LCH_TT_VEN1 = 3'h0;
   localparam logic [2:0] LCH_TT_VEN2 = 3'h1;
   localparam logic [2:0] LCH_TT_TEL2 = 3'h2;
   localparam logic [2:0] LCH_TT_TEL1 = 3'h3;
   localparam logic [2:0] LCH_TT_BSYNC = 3'h4;

   // ==========================================================
   // command codes
   localparam logic [7:0] LCH_C_TEST = 8'h00;
   localparam logic [7:0] LCH_C_WRITE = 8'h01;
   localparam logic [7:0] LCH_C_READ = 8'h02;
   localparam logic [7:0] LCH_C_NOOP = 8'h03;
   localparam logic [7:0] LCH_C_SENSE = 8'h04;
   localparam logic [7:0] LCH_C_PREPARE = 8'h06;
   localparam logic [7:0] LCH_C_POLL = 8'h09;
   localparam logic [7:0] LCH_C_INHIBIT = 8'h0A;
   localparam logic [7:0] LCH_C_BREAK = 8'h0D;
   localparam logic [7:0] LCH_C_SEARCH = 8'h0E;
   localparam logic [7:0] LCH_C_ADDPREP = 8'h0F;
   localparam logic [7:0] LCH_C_SETMODE = 8'h23;
   localparam logic [7:0] LCH_C_ENABLE = 8'h27;
   localparam logic [7:0] LCH_C_DIAL = 8'h29;
   localparam logic [7:0] LCH_C_DISABLE = 8'h2F;

   // ending status and sense bits
   localparam logic [7:0] LCH_ST_END = 8'h0C;   // channel end and device end
   localparam logic [7:0] LCH_ST_UC = 8'h02;    // unit check
   localparam logic [7:0] LCH_SNS_CREJ = 8'h80;
   localparam logic [7:0] LCH_SNS_IREQ = 8'h40;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [LCH_LINES-1:0] break_rx;
      logic [LCH_LINES-1:0] line_open;
      logic [LCH_LINES-1:0] acall_power;
      logic [LCH_LINES-1:0] acall_present;
      logic [LCH_LINES-1:0] xfer_done;
   } lch_line_in_s;

   typedef struct packed {
      logic [LCH_LINES-1:0] active;
      logic [LCH_LINES-1:0] enabled;
   } lch_line_out_s;

   typedef struct packed {
      logic [LCH_LINES-1:0]                 enable;
      logic [LCH_LINES-1:0]                 busy;
      logic [LCH_LINES-1:0][7:0]            cmd;
      logic [LCH_LINES-1:0][7:0]            sense;
      logic [LCH_LINES-1:0][7:0]            stat;
      logic [LCH_LINES-1:0]                 pend;
      logic [LCH_LINES-1:0][LCH_CFG_W-1:0]  cfg;
      logic [LCH_LINES-1:0][LCH_TMR_W-1:0]  open_cnt;
      logic [7:0]                           sdata;
      logic                                 sdata_valid;
      logic [LCH_LINE_W-1:0]                rd_line;
      logic                                 rd_hit;
      logic [31:0]                          prdata;
   } lch_state_s;

endpackage

// ---- src/lch_line_cmd.sv ----
`timescale 1ns/1ps
// Overview of operation
// - halt on a busy line stops its data transfers and frees the channel at once
// - halt on an idle line frees the channel and presents no status
// - enable sets the line's enable latch, no data moves
// - disable clears the line's enable latch, no data moves
// - sense returns exactly one byte, the line's sense field
// - start/stop: search, break on vendor types, poll on telegraph types rejected
// - start/stop: add-prepare and set-mode always rejected
// - start/stop dial rejected on vendor II, telegraph I, or without auto-calling
// - any unimplemented command code is rejected
// - bsync: read, poll, prepare, enable, disable, set-mode rejected in transparent wait
// - bsync: dial rejected in transparent wait or without auto-calling
// - bsync: break and inhibit always rejected
// - bsync: search, add-prepare rejected in transparent wait or without station selection
// - telegraph I write/prepare/search, telegraph II break on disabled line: intervention
// - vendor I write with interrupt terminal: received break raises intervention
// - start/stop read, inhibit, poll: line open over one character time raises intervention
// - telegraph I search: not enabled or open too long raises intervention
// - dial: auto-calling set powered off or absent raises intervention
// - each new command clears sense, except no-op, halt, test and sense
module lch_line_cmd
   import lch_pkg::*;
#(
   parameter int unsigned CHAR_CYCLES = LCH_CHAR_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [LCH_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire lch_line_in_s          line_in,
   output lch_line_out_s              line_out
);

   // ==========================================================
   // command classification
   function automatic logic is_known(input logic [7:0] c);
      case (c)
         LCH_C_TEST, LCH_C_WRITE, LCH_C_READ, LCH_C_NOOP, LCH_C_SENSE,
         LCH_C_PREPARE, LCH_C_POLL, LCH_C_INHIBIT, LCH_C_BREAK, LCH_C_SEARCH,
         LCH_C_ADDPREP, LCH_C_SETMODE, LCH_C_ENABLE, LCH_C_DIAL,
         LCH_C_DISABLE: is_known = 1'b1;
         default:       is_known = 1'b0;
      endcase
   endfunction

   // commands that run on and keep the line busy until ended
   function automatic logic is_long(input logic [7:0] c);
      is_long = !(c == LCH_C_TEST || c == LCH_C_NOOP || c == LCH_C_SENSE ||
                  c == LCH_C_ENABLE || c == LCH_C_DISABLE);
   endfunction

   function automatic logic [2:0] ttype(input logic [LCH_CFG_W-1:0] cf);
      ttype = cf[LCH_CFG_TYPE_LSB +: 3];
   endfunction

   // command reject decision for a line of the given configuration
   function automatic logic rejects(input logic [7:0] c, input logic [LCH_CFG_W-1:0] cf);
      logic [2:0] t;
      logic       ven;
      logic       tel;
      logic       tw;
      logic       ac;
      logic       ss;
      t = ttype(cf);
      ven = (t == LCH_TT_VEN1) || (t == LCH_TT_VEN2);
      tel = (t == LCH_TT_TEL1) || (t == LCH_TT_TEL2);
      tw = cf[LCH_CFG_TWAIT];
      ac = cf[LCH_CFG_ACALL];
      ss = cf[LCH_CFG_STASEL];
      rejects = 1'b0;
      if (!is_known(c)) begin
         rejects = 1'b1;
      end else if (t != LCH_TT_BSYNC) begin
         case (c)
            LCH_C_SEARCH:  rejects = ven;
            LCH_C_BREAK:   rejects = ven;
            LCH_C_POLL:    rejects = tel;
            LCH_C_ADDPREP,
            LCH_C_SETMODE: rejects = 1'b1;
            LCH_C_DIAL:    rejects = (t == LCH_TT_VEN2) || (t == LCH_TT_TEL1) || !ac;
            default:       rejects = 1'b0;
         endcase
      end else begin
         case (c)
            LCH_C_READ, LCH_C_POLL, LCH_C_PREPARE, LCH_C_ENABLE,
            LCH_C_DISABLE, LCH_C_SETMODE: rejects = tw;
            LCH_C_DIAL:    rejects = tw || !ac;
            LCH_C_BREAK,
            LCH_C_INHIBIT: rejects = 1'b1;
            LCH_C_SEARCH,
            LCH_C_ADDPREP: rejects = tw || !ss;
            default:       rejects = 1'b0;
         endcase
      end
   endfunction

   // intervention found already when the command is accepted
   function automatic logic ir_at_start(input logic [7:0] c, input logic [LCH_CFG_W-1:0] cf,
                                        input logic en, input logic pwr, input logic att);
      logic [2:0] t;
      t = ttype(cf);
      ir_at_start = 1'b0;
      if (t == LCH_TT_TEL1 && !en &&
          (c == LCH_C_WRITE || c == LCH_C_PREPARE || c == LCH_C_SEARCH))
         ir_at_start = 1'b1;
      if (t == LCH_TT_TEL1 && !en && (c == LCH_C_READ || c == LCH_C_INHIBIT))
         ir_at_start = 1'b1;
      if (t == LCH_TT_TEL2 && !en && c == LCH_C_BREAK)
         ir_at_start = 1'b1;
      if (c == LCH_C_DIAL && (!pwr || !att))
         ir_at_start = 1'b1;
   endfunction

   // commands during which an open line is timed
   function automatic logic watch_open(input logic [7:0] c, input logic [LCH_CFG_W-1:0] cf);
      logic [2:0] t;
      t = ttype(cf);
      watch_open = (t != LCH_TT_BSYNC &&
                    (c == LCH_C_READ || c == LCH_C_INHIBIT || c == LCH_C_POLL)) ||
                   (t == LCH_TT_TEL1 && c == LCH_C_SEARCH);
   endfunction

   // ==========================================================
   // bus decode
   lch_state_s            s_r;
   lch_state_s            s_nxt;
   logic                  setup;
   logic                  acc;
   logic                  wr;
   logic                  rd;
   logic                  aligned;
   logic                  hit_cfg;
   logic                  hit_cmd;
   logic                  hit_halt;
   logic                  hit_ro;
   logic                  mapped;
   logic [LCH_LINE_W-1:0] cfg_idx;
   logic [LCH_LINE_W-1:0] cmd_line;
   logic [LCH_LINE_W-1:0] halt_line;
   logic [7:0]            cmd_code;
   logic                  cmd_refused;

   assign setup = psel && !penable;
   assign acc = psel && penable;
   assign aligned = (paddr[1:0] == 2'h0);
   assign hit_cfg = aligned && (paddr[LCH_ADDR_W-1:LCH_LINE_W+2] ==
                                LCH_A_CFG0[LCH_ADDR_W-1:LCH_LINE_W+2]);
   assign hit_cmd = (paddr == LCH_A_CMD);
   assign hit_halt = (paddr == LCH_A_HALT);
   assign hit_ro = (paddr == LCH_A_STATUS) || (paddr == LCH_A_SDATA) ||
                   (paddr == LCH_A_LSTATE);
   assign mapped = hit_cfg || hit_cmd || hit_halt || hit_ro;
   assign cfg_idx = paddr[LCH_LINE_W+1:2];
   assign cmd_line = pwdata[LCH_CMD_LINE_LSB +: LCH_LINE_W];
   assign halt_line = pwdata[LCH_LINE_W-1:0];
   assign cmd_code = pwdata[7:0];
   // a line still busy or holding unread status takes no new command
   assign cmd_refused = hit_cmd && (s_r.busy[cmd_line] || s_r.pend[cmd_line]);
   assign wr = acc && pwrite && mapped && !hit_ro && !cmd_refused;
   assign rd = acc && !pwrite && mapped;

   // zero wait states; error on unmapped, read-only write or refused command
   assign pready = 1'b1;
   assign pslverr = acc && (!mapped || (pwrite && hit_ro) || (pwrite && cmd_refused));
   assign prdata = s_r.prdata;
   assign line_out.active = s_r.busy;
   assign line_out.enabled = s_r.enable;

   // ==========================================================
   // next state
   always_comb begin
      s_nxt = s_r;
      // read side effects first so that a set in the same cycle wins
      if (rd && paddr == LCH_A_STATUS && s_r.rd_hit)
         s_nxt.pend[s_r.rd_line] = 1'b0;
      if (rd && paddr == LCH_A_SDATA)
         s_nxt.sdata_valid = 1'b0;
      if (wr && hit_cfg)
         s_nxt.cfg[cfg_idx] = pwdata[LCH_CFG_W-1:0];

      for (int i = 0; i < LCH_LINES; i++) begin
         // running commands: open-line timer, break, normal end
         if (s_r.busy[i]) begin
            if (watch_open(s_r.cmd[i], s_r.cfg[i]) && line_in.line_open[i]) begin
               s_nxt.open_cnt[i] = s_r.open_cnt[i] + LCH_TMR_W'(1);
            end else begin
               s_nxt.open_cnt[i] = '0;
            end
            if (s_r.open_cnt[i] == LCH_TMR_W'(CHAR_CYCLES)) begin
               s_nxt.sense[i] = s_r.sense[i] | LCH_SNS_IREQ;
               s_nxt.stat[i] = LCH_ST_END | LCH_ST_UC;
               s_nxt.pend[i] = 1'b1;
               s_nxt.busy[i] = 1'b0;
            end else if (s_r.cmd[i] == LCH_C_WRITE && ttype(s_r.cfg[i]) == LCH_TT_VEN1 &&
                         s_r.cfg[i][LCH_CFG_INTR] && line_in.break_rx[i]) begin
               s_nxt.sense[i] = s_r.sense[i] | LCH_SNS_IREQ;
               s_nxt.stat[i] = LCH_ST_END | LCH_ST_UC;
               s_nxt.pend[i] = 1'b1;
               s_nxt.busy[i] = 1'b0;
            end else if (line_in.xfer_done[i]) begin
               s_nxt.stat[i] = LCH_ST_END;
               s_nxt.pend[i] = 1'b1;
               s_nxt.busy[i] = 1'b0;
            end
         end

         // halt: always frees the channel; status only if a command ran
         if (wr && hit_halt && halt_line == LCH_LINE_W'(i)) begin
            if (s_r.busy[i]) begin
               s_nxt.busy[i] = 1'b0;
               s_nxt.open_cnt[i] = '0;
               s_nxt.stat[i] = LCH_ST_END;
               s_nxt.pend[i] = 1'b1;
            end else begin
               s_nxt.pend[i] = s_nxt.pend[i];
            end
         end

         // new command; refused ones never reach here
         if (wr && hit_cmd && cmd_line == LCH_LINE_W'(i)) begin
            if (!(cmd_code == LCH_C_NOOP || cmd_code == LCH_C_TEST ||
                  cmd_code == LCH_C_SENSE))
               s_nxt.sense[i] = '0;
            s_nxt.pend[i] = 1'b1;
            s_nxt.stat[i] = LCH_ST_END;
            if (rejects(cmd_code, s_r.cfg[i])) begin
               s_nxt.sense[i] = LCH_SNS_CREJ;
               s_nxt.stat[i] = LCH_ST_END | LCH_ST_UC;
            end else if (ir_at_start(cmd_code, s_r.cfg[i], s_r.enable[i],
                                     line_in.acall_power[i], line_in.acall_present[i])) begin
               s_nxt.sense[i] = LCH_SNS_IREQ;
               s_nxt.stat[i] = LCH_ST_END | LCH_ST_UC;
            end else if (cmd_code == LCH_C_ENABLE) begin
               s_nxt.enable[i] = 1'b1;
            end else if (cmd_code == LCH_C_DISABLE) begin
               s_nxt.enable[i] = 1'b0;
            end else if (cmd_code == LCH_C_SENSE) begin
               s_nxt.sdata = s_r.sense[i];
               s_nxt.sdata_valid = 1'b1;
            end else if (is_long(cmd_code)) begin
               s_nxt.busy[i] = 1'b1;
               s_nxt.pend[i] = 1'b0;
               s_nxt.cmd[i] = cmd_code;
               s_nxt.open_cnt[i] = '0;
            end
         end
      end

      // read data is captured in the setup phase
      if (setup) begin
         s_nxt.prdata = '0;
         s_nxt.rd_hit = 1'b0;
         s_nxt.rd_line = '0;
         if (paddr == LCH_A_STATUS) begin
            // lowest line with unread status is presented first
            for (int j = LCH_LINES - 1; j >= 0; j--) begin
               if (s_r.pend[j]) begin
                  s_nxt.rd_hit = 1'b1;
                  s_nxt.rd_line = LCH_LINE_W'(j);
               end
            end
            if (s_nxt.rd_hit) begin
               s_nxt.prdata[7:0] = s_r.stat[s_nxt.rd_line];
               s_nxt.prdata[LCH_ST_LINE_LSB +: LCH_LINE_W] = s_nxt.rd_line;
               s_nxt.prdata[LCH_ST_VALID_BIT] = 1'b1;
            end
         end else if (paddr == LCH_A_SDATA) begin
            s_nxt.prdata[7:0] = s_r.sdata;
            s_nxt.prdata[LCH_SD_VALID_BIT] = s_r.sdata_valid;
         end else if (paddr == LCH_A_LSTATE) begin
            s_nxt.prdata[LCH_LINES-1:0] = s_r.enable;
            s_nxt.prdata[LCH_LS_BUSY_LSB +: LCH_LINES] = s_r.busy;
            s_nxt.prdata[LCH_LS_PEND_LSB +: LCH_LINES] = s_r.pend;
         end else if (hit_cfg) begin
            s_nxt.prdata[LCH_CFG_W-1:0] = s_r.cfg[cfg_idx];
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

// ---- verif/lch_line_cmd_checker.sv ----
`timescale 1ns/1ps
// ==========================================================
// channel-side checks on the line command block
module lch_line_cmd_chk
   import lch_pkg::*;
#(
   parameter int unsigned CHAR_CYCLES = LCH_CHAR_CYC
) (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [LCH_ADDR_W-1:0] paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire lch_line_in_s          line_in,
   input wire lch_line_out_s         line_out
);
   // decoded bus events; cmd_ok excludes refused commands
   wire logic       acc    = psel && penable;
   wire logic       wr_acc = acc && pwrite;
   wire logic [1:0] cl     = pwdata[9:8];
   wire logic [1:0] hl     = pwdata[1:0];
   wire logic [7:0] cc     = pwdata[7:0];
   wire logic       cmd_ok = wr_acc && paddr == LCH_A_CMD && !pslverr;
   wire logic       halt_w = wr_acc && paddr == LCH_A_HALT;
   logic [3:0]      bsw_r;
   // mirror of which lines are bsync in transparent wait, needed to predict enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bsw_r <= 4'h0;
      end else if (wr_acc && paddr[7:4] == 4'h1) begin
         bsw_r[paddr[3:2]] <= pwdata[2:0] == LCH_TT_BSYNC && pwdata[LCH_CFG_TWAIT];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ready_high_a: assert property (acc |-> pready)
      else $error("channel not released in first access cycle");
   halt_stop_a: assert property (
      halt_w && line_out.active[hl] |=> !line_out.active[$past(hl)])
      else $error("halt left the line transferring");
   halt_idle_a: assert property (
      halt_w && !line_out.active[hl] |=> line_out.enabled == $past(line_out.enabled))
      else $error("halt on idle line changed the line");
   enable_set_a: assert property (
      cmd_ok && cc == LCH_C_ENABLE && !bsw_r[cl]
      |=> line_out.enabled[$past(cl)] && !line_out.active[$past(cl)])
      else $error("enable did not set the latch alone");
   disable_clr_a: assert property (
      cmd_ok && cc == LCH_C_DISABLE && !bsw_r[cl]
      |=> !line_out.enabled[$past(cl)] && !line_out.active[$past(cl)])
      else $error("disable did not clear the latch alone");
   twait_keep_a: assert property (
      cmd_ok && (cc == LCH_C_ENABLE || cc == LCH_C_DISABLE) && bsw_r[cl]
      |=> $stable(line_out.enabled))
      else $error("rejected latch command changed the latch");
   start_cause_a: assert property (
      (line_out.active & ~$past(line_out.active)) != 4'h0 |-> $past(cmd_ok))
      else $error("line became busy without a command");
   short_cmd_a: assert property (
      cmd_ok && (cc == LCH_C_NOOP || cc == LCH_C_TEST || cc == LCH_C_SENSE)
      |=> !line_out.active[$past(cl)])
      else $error("short command left line busy");
   invalid_rej_a: assert property (
      cmd_ok && (cc == 8'h55 || cc == 8'hFF) |=> !line_out.active[$past(cl)])
      else $error("unknown command started a transfer");
   lstate_read_a: assert property (
      acc && !pwrite && paddr == LCH_A_LSTATE
      |-> prdata[7:0] == {$past(line_out.active), $past(line_out.enabled)})
      else $error("line state read disagrees with outputs");
endmodule

bind lch_line_cmd lch_line_cmd_chk #(.CHAR_CYCLES(CHAR_CYCLES)) lch_line_cmd_chk_i (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .line_in(line_in), .line_out(line_out));

// ---- verif/lch_line_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// line side: terminals, data sets and the data-transfer logic
module lch_line_model
   import lch_pkg::*;
#(
   parameter int DONE_CYC = 8
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire lch_line_out_s line_out,
   input  wire logic [3:0]    auto_done,
   input  wire logic [3:0]    open_req,
   input  wire logic [3:0]    brk_req,
   input  wire logic [3:0]    acall_on,
   output lch_line_in_s       line_in
);
   logic [3:0][7:0] cnt_r;
   logic [3:0]      done_r;
   // data logic finishes a running command after a fixed delay, one-cycle pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r  <= '0;
         done_r <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            done_r[i] <= line_out.active[i] && auto_done[i] && cnt_r[i] == 8'(DONE_CYC);
            cnt_r[i]  <= line_out.active[i] ? cnt_r[i] + 8'h01 : 8'h00;
         end
      end
   end
   // one bench input gives the calling set's power and attachment together
   assign line_in = {brk_req, open_req, acall_on, acall_on, done_r};
endmodule

// ---- verif/tb_line_command_halt_sense.sv ----
`timescale 1ns/1ps
module tb_line_command_halt_sense;
   import lch_pkg::*;
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
$display("MISMATCH t=%0t %s", $time, m); end end
   // ==========================================================
   // table rows: {config, command code, expected sense byte}
   localparam logic [23:0] ROWS [33] = '{
      24'h000E80, 24'h010E80, 24'h000D80, 24'h010D80, 24'h020980, 24'h030980,
      24'h000F80, 24'h032380, 24'h092980, 24'h0B2980, 24'h002980, 24'h022980,
      24'h005580, 24'h04FF80, 24'h240280, 24'h240980, 24'h240680, 24'h242780,
      24'h242F80, 24'h242380, 24'h2C2980, 24'h042980, 24'h1C0D80, 24'h1C0A80,
      24'h3C0E80, 24'h040F80, 24'h030140, 24'h030640, 24'h030E40, 24'h020D40,
      24'h082940, 24'h0A2940, 24'h002700};
   localparam logic [7:0] OPENC [3] = '{LCH_C_READ, LCH_C_INHIBIT, LCH_C_POLL};
   localparam int unsigned CHARC = 20;   // short character time keeps the run brief
   logic          clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]    paddr = 8'h00;
   logic [31:0]   pwdata = 32'h0, prdata, rq;
   logic          pready, pslverr, perr;
   logic [3:0]    auto_done = 4'h0, open_req = 4'h0, brk_req = 4'h0, acall_on = 4'h0;
   lch_line_in_s  line_in;
   lch_line_out_s line_out;
   int            nc, mismatches = 0, n_checks = 0;
   lch_line_cmd #(.CHAR_CYCLES(CHARC)) lch_line_cmd_i (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .line_in(line_in), .line_out(line_out));
   lch_line_model lch_line_model_i (.clk(clk), .rst_n(rst_n), .line_out(line_out),
      .auto_done(auto_done), .open_req(open_req), .brk_req(brk_req),
      .acall_on(acall_on), .line_in(line_in));
   // 250 MHz clock
   always #2 clk = ~clk;
   // ==========================================================
   // bus tasks; one idle cycle after each transfer avoids double drives
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rq = prdata;
      perr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cmd(input logic [1:0] l, input logic [7:0] c);
      apb(1'b1, LCH_A_CMD, {22'h0, l, c});
   endtask
   task automatic stat(input logic [1:0] l, input logic [7:0] s);
      apb(1'b0, LCH_A_STATUS, 32'h0);
      `CHK(rq[16:0], {1'b1, 6'h00, l, s}, "ending status")
   endtask
   task automatic sns(input logic [1:0] l, input logic [7:0] s);
      cmd(l, LCH_C_SENSE);
      stat(l, LCH_ST_END);
      apb(1'b0, LCH_A_SDATA, 32'h0);
      `CHK(rq[8:0], {1'b1, s}, "sense byte")
   endtask
   task automatic run(input logic [1:0] l, input logic [7:0] c, input logic [7:0] s);
      cmd(l, c);
      stat(l, (s == 8'h00) ? LCH_ST_END : (LCH_ST_END | LCH_ST_UC));
      sns(l, s);
   endtask
   task automatic wait_idle(input logic [1:0] l);
      nc = 0;
      while (line_out.active[l] === 1'b1 && nc < 200) begin
         @(posedge clk);
         nc++;
      end
      if (nc >= 200) mismatches++;   // a line that never ends is a failure
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // watchdog: the whole sequence needs about 1000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out();
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `CHK(line_out, 8'h00, "outputs after reset")
      foreach (ROWS[k]) begin
         apb(1'b1, LCH_A_CFG0, {24'h0, ROWS[k][23:16]});
         run(2'd0, ROWS[k][15:8], ROWS[k][7:0]);
         `CHK(line_out.active[0], 1'b0, "short command left line busy")
      end
      `CHK(line_out.enabled[0], 1'b1, "enable latch not set")
      run(2'd0, 8'h55, LCH_SNS_CREJ);
      cmd(2'd0, LCH_C_NOOP);
      stat(2'd0, LCH_ST_END);
      cmd(2'd0, LCH_C_TEST);
      stat(2'd0, LCH_ST_END);
      apb(1'b1, LCH_A_HALT, 32'h0);
      apb(1'b0, LCH_A_STATUS, 32'h0);
      `CHK(rq[16], 1'b0, "idle halt presented status")
      sns(2'd0, LCH_SNS_CREJ);
      run(2'd0, LCH_C_DISABLE, 8'h00);
      `CHK(line_out.enabled[0], 1'b0, "enable latch not cleared")
      apb(1'b1, LCH_A_STATUS, 32'h0);
      `CHK(perr, 1'b1, "write to status accepted")
      apb(1'b0, 8'h30, 32'h0);
      `CHK(perr, 1'b1, "unmapped read accepted")
      // long commands on line 1, then halt in mid-transfer
      cmd(2'd1, LCH_C_READ);
      `CHK(line_out.active[1], 1'b1, "read not running")
      apb(1'b0, LCH_A_LSTATE, 32'h0);
      `CHK(rq[11:0], 12'h020, "line state during read")
      cmd(2'd1, LCH_C_READ);
      `CHK(perr, 1'b1, "command to busy line accepted")
      apb(1'b1, LCH_A_HALT, 32'h1);
      `CHK(line_out.active[1], 1'b0, "halt left transfers running")
      stat(2'd1, LCH_ST_END);
      auto_done[1] <= 1'b1;
      cmd(2'd1, LCH_C_WRITE);
      wait_idle(2'd1);
      stat(2'd1, LCH_ST_END);
      auto_done[1] <= 1'b0;
      apb(1'b1, LCH_A_CFG0 + 8'h04, 32'h40);
      cmd(2'd1, LCH_C_WRITE);
      brk_req[1] <= 1'b1;
      wait_idle(2'd1);
      brk_req[1] <= 1'b0;
      stat(2'd1, LCH_ST_END | LCH_ST_UC);
      sns(2'd1, LCH_SNS_IREQ);
      // open line during receive-type commands
      apb(1'b1, LCH_A_CFG0 + 8'h08, 32'h1);
      foreach (OPENC[k]) begin
         cmd(2'd2, OPENC[k]);
         open_req[2] <= 1'b1;
         wait_idle(2'd2);
         open_req[2] <= 1'b0;
         `CHK(nc >= 15 && nc <= 30, 1'b1, "open line timeout length")
         stat(2'd2, LCH_ST_END | LCH_ST_UC);
         sns(2'd2, LCH_SNS_IREQ);
      end
      apb(1'b1, LCH_A_CFG0 + 8'h0C, 32'h3);
      run(2'd3, LCH_C_ENABLE, 8'h00);
      cmd(2'd3, LCH_C_SEARCH);
      open_req[3] <= 1'b1;
      wait_idle(2'd3);
      open_req[3] <= 1'b0;
      stat(2'd3, LCH_ST_END | LCH_ST_UC);
      sns(2'd3, LCH_SNS_IREQ);
      // dial with a powered calling set, then without
      acall_on[0] <= 1'b1;
      apb(1'b1, LCH_A_CFG0, 32'h8);
      cmd(2'd0, LCH_C_DIAL);
      `CHK(line_out.active[0], 1'b1, "dial refused")
      apb(1'b1, LCH_A_HALT, 32'h0);
      stat(2'd0, LCH_ST_END);
      acall_on[0] <= 1'b0;
      run(2'd0, LCH_C_DIAL, LCH_SNS_IREQ);
      // second reset with status pending
      cmd(2'd3, LCH_C_SENSE);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `CHK(line_out, 8'h00, "outputs after second reset")
      apb(1'b0, LCH_A_STATUS, 32'h0);
      `CHK(rq[16], 1'b0, "status kept over reset")
      close_out();
   end
endmodule
